// *** design/auto_cal_trigger.sv ***
// Purpose: Decides when the synthesizer calibration starts
// Assumes: Event inputs are one-cycle pulses on core_clk_i
// Notes:   Return counter only advances while the every-fourth mode is selected

`timescale 1ns/10ps

module auto_cal_trigger (
	// Clock and reset
	input  wire logic       core_clk_i,
	input  wire logic       rst_i,
	// Settings and events
	input  wire logic [1:0] auto_cal_select_i,
	input  wire logic       idle_exit_i,
	input  wire logic       auto_return_i,
	input  wire logic       calibrate_strobe_i,
	// Calibration start pulse
	output logic            cal_start_o
);

	logic [1:0] returns_q;
	logic [1:0] returns_d;
	logic       cal_q;
	logic       cal_d;

	// Next calibration pulse and return count
	always_comb begin
		returns_d = returns_q;
		cal_d     = calibrate_strobe_i;
		unique case (radio_cfg_pkg::auto_cal_e'(auto_cal_select_i))
			radio_cfg_pkg::CAL_NEVER: begin
				cal_d = calibrate_strobe_i;
			end
			radio_cfg_pkg::CAL_ON_START: begin
				cal_d = calibrate_strobe_i | idle_exit_i;
			end
			radio_cfg_pkg::CAL_ON_RETURN: begin
				cal_d = calibrate_strobe_i | auto_return_i;
			end
			radio_cfg_pkg::CAL_EVERY_FOURTH: begin
				if (auto_return_i) begin
					returns_d = returns_q + 2'h1;
					cal_d     = calibrate_strobe_i | (returns_q == radio_cfg_pkg::FOURTH_RETURN);
				end
			end
		endcase
	end

	// Register state
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			returns_q <= 2'h0;
			cal_q     <= 1'b0;
		end else begin
			returns_q <= returns_d;
			cal_q     <= cal_d;
		end
	end

	assign cal_start_o = cal_q;

	// Every-fourth mode: four returns give exactly one calibration
	fourth_only_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(auto_cal_select_i == radio_cfg_pkg::CAL_EVERY_FOURTH) && auto_return_i
		&& !calibrate_strobe_i && (returns_q != radio_cfg_pkg::FOURTH_RETURN)
		|=> !cal_start_o)
		else $error("calibration on a return other than the fourth");

endmodule : auto_cal_trigger

// *** design/power_on_expiry.sv ***
// Purpose: Holds chip ready off until the ripple counter expired enough times
// Assumes: osc_running_i is already synchronised to core_clk_i
// Notes:   Losing the oscillator restarts the whole count

`timescale 1ns/10ps

module power_on_expiry (
	// Clock and reset
	input  wire logic       core_clk_i,
	input  wire logic       rst_i,
	// Settings and oscillator state
	input  wire logic [1:0] expiry_select_i,
	input  wire logic       osc_running_i,
	// Active-low chip ready
	output logic            chip_ready_n_out_o
);

	typedef enum logic [2:0] {
		EXP_OFF   = 3'b001,
		EXP_COUNT = 3'b010,
		EXP_DONE  = 3'b100
	} exp_state_e;

	exp_state_e                           state_q;
	exp_state_e                           state_d;
	logic [radio_cfg_pkg::RIPPLE_W-1:0]   ripple_q;
	logic [radio_cfg_pkg::RIPPLE_W-1:0]   ripple_d;
	logic [radio_cfg_pkg::EXPIRY_W-1:0]   expired_q;
	logic [radio_cfg_pkg::EXPIRY_W-1:0]   expired_d;
	logic                                 ready_n_q;
	logic                                 ready_n_d;

	// Count ripple wraps after the oscillator starts
	always_comb begin
		state_d   = state_q;
		ripple_d  = ripple_q;
		expired_d = expired_q;
		ready_n_d = 1'b1;
		unique case (state_q)
			EXP_OFF: begin
				ripple_d  = '0;
				expired_d = '0;
				if (osc_running_i) begin
					state_d = EXP_COUNT;
				end
			end
			EXP_COUNT: begin
				ripple_d = ripple_q + 6'h01;
				if (ripple_q == radio_cfg_pkg::RIPPLE_LAST) begin
					expired_d = expired_q + 9'h001;
				end
				if (expired_q >= radio_cfg_pkg::expiry_target(expiry_select_i)) begin
					state_d   = EXP_DONE;
					ready_n_d = 1'b0;
				end
			end
			EXP_DONE: begin
				ready_n_d = 1'b0;
			end
		endcase
		if (!osc_running_i) begin
			state_d   = EXP_OFF;
			ready_n_d = 1'b1;
		end
	end

	// Register state
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_q   <= EXP_OFF;
			ripple_q  <= '0;
			expired_q <= '0;
			ready_n_q <= 1'b1;
		end else begin
			state_q   <= state_d;
			ripple_q  <= ripple_d;
			expired_q <= expired_d;
			ready_n_q <= ready_n_d;
		end
	end

	assign chip_ready_n_out_o = ready_n_q;

	// Ready only falls once the selected expiry count has been reached
	ready_fall_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		$fell(chip_ready_n_out_o)
		|-> $past(expired_q) >= radio_cfg_pkg::expiry_target($past(expiry_select_i)))
		else $error("chip ready asserted before expiry count");

endmodule : power_on_expiry

// *** design/radio_cal_and_offset_comp_config.sv ***
// Purpose: Settings registers for synthesizer calibration and offset compensation
// Assumes: Register port comes from the serial decoder on core_clk_i
// Notes:   Pin inputs and oscillator status pass a three-stage filter

`timescale 1ns/10ps

// Notes on behaviour
// - Selector zero: calibrate only on strobe
// - Selector one: calibrate leaving idle
// - Selector two: calibrate on automatic idle return
// - Selector three: calibrate every fourth return
// - Chip ready after selected ripple expiries
// - Gate bit freezes loops until carrier
// - Pre-sync gain K to 4K
// - Post-sync gain same or K/2
// - Limit zero, eighth, quarter, half bandwidth
module radio_cal_and_offset_comp_config (
	// Clock and reset
	input  wire logic       core_clk_i,
	input  wire logic       rst_i,
	// Register port
	input  wire logic [5:0] reg_addr_i,
	input  wire logic [7:0] reg_wdata_i,
	input  wire logic       reg_wr_i,
	input  wire logic       reg_rd_i,
	output logic      [7:0] reg_rdata_o,
	// Radio state events
	input  wire logic       idle_exit_i,
	input  wire logic       auto_return_i,
	input  wire logic       calibrate_strobe_i,
	output logic            cal_start_o,
	// Crystal oscillator
	input  wire logic       osc_running_i,
	input  wire logic       sleep_i,
	output logic            osc_enable_o,
	output logic            chip_ready_n_out_o,
	// Demodulator loops
	input  wire logic       carrier_sense_i,
	input  wire logic       sync_found_i,
	output logic            loop_freeze_o,
	output logic      [3:0] offset_gain_o,
	output logic      [1:0] offset_limit_o,
	output logic            offset_comp_en_o,
	// Radio control pins
	input  wire logic [1:0] radio_pins_i,
	output logic      [1:0] radio_pin_req_o
);

	localparam int SYNC_W = 3;

	// Configuration registers
	logic [7:0] main_ctrl_q;
	logic [7:0] main_ctrl_d;
	logic [7:0] offset_comp_q;
	logic [7:0] offset_comp_d;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;

	// Field views
	logic [1:0] auto_cal_select;
	logic [1:0] power_on_expiry_select;
	logic       pin_ctrl_en;
	logic       osc_keep_on_in_sleep;
	logic       freeze_loops_until_carrier;
	logic [1:0] offset_gain_pre_sync;
	logic       offset_gain_post_sync;
	logic [1:0] offset_comp_limit;

	// Filtered outside inputs
	logic [SYNC_W-1:0] raw_in;
	logic [SYNC_W-1:0] stage1_q;
	logic [SYNC_W-1:0] stage2_q;
	logic [SYNC_W-1:0] stage3_q;
	logic [SYNC_W-1:0] filt_q;
	logic [SYNC_W-1:0] filt_d;
	logic              osc_running_f;
	logic [1:0]        pins_f;

	// Demodulator, pin and oscillator outputs
	logic       freeze_q;
	logic       freeze_d;
	logic [3:0] gain_q;
	logic [3:0] gain_d;
	logic [1:0] limit_q;
	logic [1:0] limit_d;
	logic       comp_en_q;
	logic       comp_en_d;
	logic [1:0] pin_req_q;
	logic [1:0] pin_req_d;
	logic       osc_en_q;
	logic       osc_en_d;

	// Field extraction
	assign auto_cal_select            = main_ctrl_q[radio_cfg_pkg::AUTO_CAL_LSB +: 2];
	assign power_on_expiry_select     = main_ctrl_q[radio_cfg_pkg::EXPIRY_SEL_LSB +: 2];
	assign pin_ctrl_en                = main_ctrl_q[radio_cfg_pkg::PIN_CTRL_BIT];
	assign osc_keep_on_in_sleep       = main_ctrl_q[radio_cfg_pkg::KEEP_ON_BIT];
	assign freeze_loops_until_carrier = offset_comp_q[radio_cfg_pkg::FREEZE_BIT];
	assign offset_gain_pre_sync       = offset_comp_q[radio_cfg_pkg::PRE_GAIN_LSB +: 2];
	assign offset_gain_post_sync      = offset_comp_q[radio_cfg_pkg::POST_GAIN_BIT];
	assign offset_comp_limit          = offset_comp_q[radio_cfg_pkg::LIMIT_LSB +: 2];

	// Register writes and reads; reserved bits stay zero
	always_comb begin
		main_ctrl_d   = main_ctrl_q;
		offset_comp_d = offset_comp_q;
		rdata_d       = rdata_q;
		if (reg_wr_i) begin
			if (reg_addr_i == radio_cfg_pkg::MAIN_CTRL_ADDR) begin
				main_ctrl_d = reg_wdata_i & radio_cfg_pkg::WRITABLE_MASK;
			end
			if (reg_addr_i == radio_cfg_pkg::OFFSET_COMP_ADDR) begin
				offset_comp_d = reg_wdata_i & radio_cfg_pkg::WRITABLE_MASK;
			end
		end
		if (reg_rd_i) begin
			if (reg_addr_i == radio_cfg_pkg::MAIN_CTRL_ADDR) begin
				rdata_d = main_ctrl_q;
			end else if (reg_addr_i == radio_cfg_pkg::OFFSET_COMP_ADDR) begin
				rdata_d = offset_comp_q;
			end else begin
				rdata_d = 8'h00; // Unmapped address reads zero
			end
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			main_ctrl_q   <= radio_cfg_pkg::MAIN_CTRL_RESET;
			offset_comp_q <= radio_cfg_pkg::OFFSET_COMP_RESET;
			rdata_q       <= 8'h00;
		end else begin
			main_ctrl_q   <= main_ctrl_d;
			offset_comp_q <= offset_comp_d;
			rdata_q       <= rdata_d;
		end
	end

	assign reg_rdata_o = rdata_q;

	// Three-stage filter; a change counts once stages two and three agree
	assign raw_in = {radio_pins_i, osc_running_i};

	generate
		for (genvar i = 0; i < SYNC_W; i++) begin : g_filt
			always_comb begin
				filt_d[i] = (stage2_q[i] == stage3_q[i]) ? stage3_q[i] : filt_q[i];
			end
		end
	endgenerate

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			stage1_q <= '0;
			stage2_q <= '0;
			stage3_q <= '0;
			filt_q   <= '0;
		end else begin
			stage1_q <= raw_in;
			stage2_q <= stage1_q;
			stage3_q <= stage2_q;
			filt_q   <= filt_d;
		end
	end

	assign osc_running_f = filt_q[0];
	assign pins_f        = filt_q[2:1];

	// Calibration trigger
	auto_cal_trigger u_cal (
		.core_clk_i         (core_clk_i),
		.rst_i              (rst_i),
		.auto_cal_select_i  (auto_cal_select),
		.idle_exit_i        (idle_exit_i),
		.auto_return_i      (auto_return_i),
		.calibrate_strobe_i (calibrate_strobe_i),
		.cal_start_o        (cal_start_o)
	);

	// Chip ready after oscillator start
	power_on_expiry u_expiry (
		.core_clk_i         (core_clk_i),
		.rst_i              (rst_i),
		.expiry_select_i    (power_on_expiry_select),
		.osc_running_i      (osc_running_f),
		.chip_ready_n_out_o (chip_ready_n_out_o)
	);

	// Loop freeze, gain, limit, pin control and oscillator keep-on
	always_comb begin
		freeze_d  = freeze_loops_until_carrier & ~carrier_sense_i;
		gain_d    = radio_cfg_pkg::pre_gain_halves(offset_gain_pre_sync);
		if (sync_found_i && offset_gain_post_sync) begin
			gain_d = radio_cfg_pkg::GAIN_HALF_K;
		end
		limit_d   = offset_comp_limit;
		comp_en_d = offset_comp_limit != radio_cfg_pkg::LIMIT_OFF;
		pin_req_d = pin_ctrl_en ? pins_f : 2'h0;
		osc_en_d  = ~sleep_i | osc_keep_on_in_sleep;
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			freeze_q  <= 1'b0;
			gain_q    <= 4'h0;
			limit_q   <= 2'h0;
			comp_en_q <= 1'b0;
			pin_req_q <= 2'h0;
			osc_en_q  <= 1'b0;
		end else begin
			freeze_q  <= freeze_d;
			gain_q    <= gain_d;
			limit_q   <= limit_d;
			comp_en_q <= comp_en_d;
			pin_req_q <= pin_req_d;
			osc_en_q  <= osc_en_d;
		end
	end

	assign loop_freeze_o    = freeze_q;
	assign offset_gain_o    = gain_q;
	assign offset_limit_o   = limit_q;
	assign offset_comp_en_o = comp_en_q;
	assign radio_pin_req_o  = pin_req_q;
	assign osc_enable_o     = osc_en_q;

	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (rst_i);

	// Selector zero: no calibration without a strobe
	never_auto_a: assert property (
		(auto_cal_select == radio_cfg_pkg::CAL_NEVER) && !calibrate_strobe_i
		&& $stable(main_ctrl_q) |=> !cal_start_o)
		else $error("calibration started without strobe in manual mode");

	// Selector one: leaving idle calibrates next cycle
	start_cal_a: assert property (
		(auto_cal_select == radio_cfg_pkg::CAL_ON_START) && idle_exit_i |=> cal_start_o)
		else $error("no calibration on leaving idle");

	// Selector two: automatic return calibrates next cycle
	return_cal_a: assert property (
		(auto_cal_select == radio_cfg_pkg::CAL_ON_RETURN) && auto_return_i |=> cal_start_o)
		else $error("no calibration on return to idle");

	// Strobe always calibrates
	strobe_cal_a: assert property (
		calibrate_strobe_i |=> cal_start_o)
		else $error("calibrate strobe ignored");

	// Freeze follows gate bit and carrier sense
	loop_freeze_a: assert property (
		freeze_loops_until_carrier && !carrier_sense_i |=> loop_freeze_o)
		else $error("loops not frozen before carrier");

	// Carrier releases the freeze
	freeze_release_a: assert property (
		carrier_sense_i |=> !loop_freeze_o)
		else $error("loops frozen with carrier present");

	// Pre-sync gain is (code+1) times K
	pre_gain_a: assert property (
		!sync_found_i |=> offset_gain_o == {1'b0, $past(offset_gain_pre_sync), 1'b0}
		+ 4'h2)
		else $error("wrong gain before sync");

	// Post-sync gain is K/2 or unchanged
	post_gain_a: assert property (
		sync_found_i && !offset_gain_post_sync
		|=> offset_gain_o == {1'b0, $past(offset_gain_pre_sync), 1'b0} + 4'h2)
		else $error("post-sync gain differs from pre-sync");

	half_gain_a: assert property (
		sync_found_i && offset_gain_post_sync |=> offset_gain_o == 4'h1)
		else $error("post-sync gain is not K/2");

	// Limit code reaches output; zero disables compensation
	comp_limit_a: assert property (
		1'b1 |=> (offset_limit_o == $past(offset_comp_limit))
		&& (offset_comp_en_o == ($past(offset_comp_limit) != 2'h0)))
		else $error("compensation limit wrong");

	// Pins only reach the radio when enabled; oscillator kept in sleep when keep-on is set
	pin_ctrl_a: assert property (
		!pin_ctrl_en |=> radio_pin_req_o == 2'h0)
		else $error("pin request while pin control disabled");

	keep_osc_a: assert property (
		osc_keep_on_in_sleep |=> osc_enable_o)
		else $error("oscillator stopped despite keep-on");

endmodule : radio_cal_and_offset_comp_config

// *** design/radio_cfg_pkg.sv ***
// Purpose: Shared constants for the calibration and offset compensation settings
// Assumes: Register port addresses are six bits wide, data eight bits
// Notes:   Reserved bits 7:6 of both registers read as zero

package radio_cfg_pkg;

	// Register addresses
	localparam logic [5:0] MAIN_CTRL_ADDR   = 6'h18;
	localparam logic [5:0] OFFSET_COMP_ADDR = 6'h19;

	// Reset values and writable bit masks
	localparam logic [7:0] MAIN_CTRL_RESET   = 8'h04;
	localparam logic [7:0] OFFSET_COMP_RESET = 8'h36;
	localparam logic [7:0] WRITABLE_MASK     = 8'h3F;

	// Field positions, main control register
	localparam int AUTO_CAL_LSB   = 4;
	localparam int EXPIRY_SEL_LSB = 2;
	localparam int PIN_CTRL_BIT   = 1;
	localparam int KEEP_ON_BIT    = 0;

	// Field positions, offset compensation register
	localparam int FREEZE_BIT     = 5;
	localparam int PRE_GAIN_LSB   = 3;
	localparam int POST_GAIN_BIT  = 2;
	localparam int LIMIT_LSB      = 0;

	// Auto calibration selector codes
	typedef enum logic [1:0] {
		CAL_NEVER        = 2'h0,
		CAL_ON_START     = 2'h1,
		CAL_ON_RETURN    = 2'h2,
		CAL_EVERY_FOURTH = 2'h3
	} auto_cal_e;

	// Return counter value that marks the fourth return
	localparam logic [1:0] FOURTH_RETURN = 2'h3;

	// Power-on expiry counter widths
	localparam int RIPPLE_W = 6;
	localparam int EXPIRY_W = 9;
	localparam logic [RIPPLE_W-1:0] RIPPLE_LAST = 6'h3F;

	// Expiry counts for selector codes
	localparam logic [EXPIRY_W-1:0] EXPIRY_CNT_0 = 9'h001;
	localparam logic [EXPIRY_W-1:0] EXPIRY_CNT_1 = 9'h010;
	localparam logic [EXPIRY_W-1:0] EXPIRY_CNT_2 = 9'h040;
	localparam logic [EXPIRY_W-1:0] EXPIRY_CNT_3 = 9'h100;

	// Gain in units of K/2, and limit code meaning disabled
	localparam logic [3:0] GAIN_HALF_K  = 4'h1;
	localparam logic [1:0] LIMIT_OFF    = 2'h0;

	// Number of ripple expiries needed for a selector code
	function automatic logic [EXPIRY_W-1:0] expiry_target(input logic [1:0] sel);
		logic [EXPIRY_W-1:0] t;
		t = EXPIRY_CNT_0;
		case (sel)
			2'h0: t = EXPIRY_CNT_0;
			2'h1: t = EXPIRY_CNT_1;
			2'h2: t = EXPIRY_CNT_2;
			default: t = EXPIRY_CNT_3;
		endcase
		return t;
	endfunction : expiry_target

	// Pre-sync gain (code+1)*K expressed in K/2 units
	function automatic logic [3:0] pre_gain_halves(input logic [1:0] code);
		logic [2:0] mult;
		mult = {1'b0, code} + 3'h1;
		return {mult, 1'b0};
	endfunction : pre_gain_halves

endpackage : radio_cfg_pkg

// *** dv/tb.sv ***
// Purpose: Self-checking bench for the calibration and offset compensation settings
// Assumes: Outputs settle one cycle after a register write or an input change
// Notes:   Filter and expiry latencies are checked in windows, not to the exact cycle

`timescale 1ns/10ps

module tb;

	// Clock, reset and design ports
	logic       core_clk_i = 1'b0;
	logic       rst_i = 1'b1;
	logic [5:0] reg_addr_i = 6'h00;
	logic [7:0] reg_wdata_i = 8'h00;
	logic       reg_wr_i = 1'b0;
	logic       reg_rd_i = 1'b0;
	logic [7:0] reg_rdata_o;
	logic       idle_exit_i = 1'b0;
	logic       auto_return_i = 1'b0;
	logic       calibrate_strobe_i = 1'b0;
	logic       cal_start_o;
	logic       osc_running_i = 1'b0;
	logic       sleep_i = 1'b0;
	logic       osc_enable_o;
	logic       chip_ready_n_out_o;
	logic       carrier_sense_i = 1'b1;
	logic       sync_found_i = 1'b0;
	logic       loop_freeze_o;
	logic [3:0] offset_gain_o;
	logic [1:0] offset_limit_o;
	logic       offset_comp_en_o;
	logic [1:0] radio_pins_i = 2'h0;
	logic [1:0] radio_pin_req_o;

	// Bench bookkeeping
	int         failures = 0;
	int         checks = 0;
	int         cycles = 0;
	int         n;

	// One row of the demodulator settings table
	typedef struct {
		logic [7:0] cfg;
		logic       sync;
		logic       cs;
		logic [3:0] gain;
		logic [1:0] lim;
		logic       frz;
	} row_s;
	row_s rows[8];

	// 200 MHz clock
	always #2.5 core_clk_i = ~core_clk_i;

	radio_cal_and_offset_comp_config radio_cal_and_offset_comp_config_inst (
		.core_clk_i         (core_clk_i),
		.rst_i              (rst_i),
		.reg_addr_i         (reg_addr_i),
		.reg_wdata_i        (reg_wdata_i),
		.reg_wr_i           (reg_wr_i),
		.reg_rd_i           (reg_rd_i),
		.reg_rdata_o        (reg_rdata_o),
		.idle_exit_i        (idle_exit_i),
		.auto_return_i      (auto_return_i),
		.calibrate_strobe_i (calibrate_strobe_i),
		.cal_start_o        (cal_start_o),
		.osc_running_i      (osc_running_i),
		.sleep_i            (sleep_i),
		.osc_enable_o       (osc_enable_o),
		.chip_ready_n_out_o (chip_ready_n_out_o),
		.carrier_sense_i    (carrier_sense_i),
		.sync_found_i       (sync_found_i),
		.loop_freeze_o      (loop_freeze_o),
		.offset_gain_o      (offset_gain_o),
		.offset_limit_o     (offset_limit_o),
		.offset_comp_en_o   (offset_comp_en_o),
		.radio_pins_i       (radio_pins_i),
		.radio_pin_req_o    (radio_pin_req_o)
	);

	// Verdict and end of run
	task automatic report_and_stop();
		$display("checks=%0d failures=%0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : report_and_stop

	// Cuts a hang short
	always @(posedge core_clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			report_and_stop();
		end
	end

	// Compare one value
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// Register write, one strobe cycle
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge core_clk_i);
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		reg_wr_i    <= 1'b1;
		@(posedge core_clk_i);
		reg_wr_i    <= 1'b0;
	endtask : wr

	// Register read, data checked one cycle after the strobe edge
	task automatic rd(input logic [5:0] a, input logic [7:0] exp);
		@(posedge core_clk_i);
		reg_addr_i <= a;
		reg_rd_i   <= 1'b1;
		@(posedge core_clk_i);
		reg_rd_i   <= 1'b0;
		#1 chk(reg_rdata_o, exp);
	endtask : rd

	// One event pulse; calibration start expected on the next cycle only
	task automatic pulse(input int kind, input logic exp);
		@(posedge core_clk_i);
		idle_exit_i        <= (kind == 0);
		auto_return_i      <= (kind == 1);
		calibrate_strobe_i <= (kind == 2);
		@(posedge core_clk_i);
		idle_exit_i        <= 1'b0;
		auto_return_i      <= 1'b0;
		calibrate_strobe_i <= 1'b0;
		#1 chk({7'h00, cal_start_o}, {7'h00, exp});
		@(posedge core_clk_i);
		#1 chk({7'h00, cal_start_o}, 8'h00);
	endtask : pulse

	// Measure cycles from oscillator start to chip ready
	task automatic power_up(input int lo, input int hi);
		@(posedge core_clk_i);
		osc_running_i <= 1'b1;
		n = 0;
		while (chip_ready_n_out_o !== 1'b0 && n < hi) begin
			@(posedge core_clk_i);
			#1 n++; // Sample after the edge has settled
		end
		chk({7'h00, chip_ready_n_out_o}, 8'h00);
		chk({7'h00, 1'(n >= lo)}, 8'h01);
	endtask : power_up

	initial begin
		rows = '{
			'{8'h00, 1'b0, 1'b0, 4'h2, 2'h0, 1'b0},
			'{8'h08, 1'b0, 1'b1, 4'h4, 2'h0, 1'b0},
			'{8'h11, 1'b0, 1'b1, 4'h6, 2'h1, 1'b0},
			'{8'h1A, 1'b0, 1'b1, 4'h8, 2'h2, 1'b0},
			'{8'h1F, 1'b1, 1'b1, 4'h1, 2'h3, 1'b0},
			'{8'h1B, 1'b1, 1'b1, 4'h8, 2'h3, 1'b0},
			'{8'h27, 1'b0, 1'b0, 4'h2, 2'h3, 1'b1},
			'{8'h27, 1'b1, 1'b1, 4'h1, 2'h3, 1'b0}
		};
		repeat (10) @(posedge core_clk_i);
		rst_i <= 1'b0;
		// Reset values, unmapped address, reserved bits
		rd(6'h18, 8'h04);
		rd(6'h19, 8'h36);
		rd(6'h1A, 8'h00);
		wr(6'h19, 8'hFF);
		rd(6'h19, 8'h3F);
		// Demodulator settings table
		foreach (rows[i]) begin
			wr(6'h19, rows[i].cfg);
			sync_found_i    <= rows[i].sync;
			carrier_sense_i <= rows[i].cs;
			repeat (3) @(posedge core_clk_i);
			#1 chk({4'h0, offset_gain_o}, {4'h0, rows[i].gain});
			chk({6'h00, offset_limit_o}, {6'h00, rows[i].lim});
			chk({7'h00, offset_comp_en_o}, {7'h00, 1'(rows[i].lim != 2'h0)});
			chk({7'h00, loop_freeze_o}, {7'h00, rows[i].frz});
		end
		// Power-on expiry with reset selector, then selector zero
		power_up(1024, 1040);
		@(posedge core_clk_i);
		osc_running_i <= 1'b0;
		repeat (8) @(posedge core_clk_i);
		#1 chk({7'h00, chip_ready_n_out_o}, 8'h01);
		wr(6'h18, 8'h00);
		power_up(64, 80);
		// Calibration modes never, on start, on return
		for (int m = 0; m < 3; m++) begin
			wr(6'h18, 8'(m << 4));
			pulse(0, m == 1);
			pulse(1, m == 2);
		end
		wr(6'h18, 8'h00);
		pulse(2, 1'b1);
		// Every fourth return, start events ignored
		wr(6'h18, 8'h30);
		pulse(0, 1'b0);
		for (int i = 0; i < 8; i++) begin
			pulse(1, i == 3 || i == 7);
		end
		// Oscillator kept on in sleep only when asked
		wr(6'h18, 8'h00);
		sleep_i <= 1'b1;
		repeat (3) @(posedge core_clk_i);
		#1 chk({7'h00, osc_enable_o}, 8'h00);
		wr(6'h18, 8'h01);
		repeat (3) @(posedge core_clk_i);
		#1 chk({7'h00, osc_enable_o}, 8'h01);
		wr(6'h18, 8'h00);
		sleep_i <= 1'b0;
		repeat (3) @(posedge core_clk_i);
		#1 chk({7'h00, osc_enable_o}, 8'h01);
		// Pin control passes pins only when enabled
		@(posedge core_clk_i);
		radio_pins_i <= 2'h2;
		repeat (8) @(posedge core_clk_i);
		#1 chk({6'h00, radio_pin_req_o}, 8'h00);
		wr(6'h18, 8'h02);
		repeat (8) @(posedge core_clk_i);
		#1 chk({6'h00, radio_pin_req_o}, 8'h02);
		// Reserved bits of the control register read as zero
		wr(6'h18, 8'hFF);
		rd(6'h18, 8'h3F);
		// Mid-run reset restores outputs and register values
		@(posedge core_clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge core_clk_i);
		#1 chk({7'h00, chip_ready_n_out_o}, 8'h01);
		chk({7'h00, osc_enable_o}, 8'h00);
		chk({6'h00, radio_pin_req_o}, 8'h00);
		chk(reg_rdata_o, 8'h00);
		@(posedge core_clk_i);
		rst_i <= 1'b0;
		rd(6'h18, 8'h04);
		rd(6'h19, 8'h36);
		report_and_stop();
	end

endmodule : tb
